// ===== logic/cku_checksum_unit.sv
// Byte-serial checksum unit with AHB-Lite registers and flash sweep
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cku_checksum_unit
    import cku_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic                     flash_rd,
    output logic [FLASH_AW-1:0]      flash_addr,
    input  wire logic                flash_rd_valid,
    input  wire logic [7:0]          flash_rd_data
);

    // Bus phase tracking
    logic                   dp_valid_reg;
    logic                   dp_write_reg;
    logic [7:0]             dp_addr_reg;
    logic                   dp_mapped_reg;
    logic [31:0]            hrdata_reg;
    logic                   hreadyout_reg;
    logic                   hresp_reg;

    // Software visible state
    logic [31:0]            result_reg;
    logic                   poly_select_reg;
    logic                   preset_value_select_reg;
    logic [1:0]             result_byte_pointer_reg;
    logic [7:0]             byte_input_reg;
    logic                   auto_flash_enable_reg;
    logic [PAGE_W-1:0]      start_page_reg;
    logic [COUNT_W-1:0]     sector_count_reg;
    logic [7:0]             bitrev_reg;

    // Sequencer
    cku_state_t             state_reg;
    logic [REMAIN_W-1:0]    remain_reg;
    logic                   flash_rd_reg;
    logic [FLASH_AW-1:0]    flash_addr_reg;

    // Decoded strobes
    logic                   addr_take;
    logic                   dp_wr;
    logic                   wr_ctrl;
    logic                   wr_input;
    logic                   wr_window;
    logic                   wr_auto;
    logic                   wr_count;
    logic                   wr_bitrev;
    logic                   rd_window;
    logic                   auto_en_eff;
    logic                   auto_start;
    logic                   auto_byte;
    logic [1:0]             lane;
    logic [7:0]             window_byte;
    logic [7:0]             bitrev_view;

    // One byte through the MSB-first 16-bit generator
    function automatic logic [15:0] crc16_byte(input logic [15:0] acc, input logic [7:0] din);
        logic [15:0] c;
        c = acc ^ {din, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            c = c[15] ? ({c[14:0], 1'b0} ^ POLY16) : {c[14:0], 1'b0};
        end
        return c;
    endfunction

    // One byte through the reflected 32-bit generator
    function automatic logic [31:0] crc32_byte(input logic [31:0] acc, input logic [7:0] din);
        logic [31:0] c;
        c = acc ^ {24'h000000, din};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ POLY32_REFL) : (c >> 1);
        end
        return c;
    endfunction

    // Fold a byte in the selected width; upper half left alone in 16-bit mode
    function automatic logic [31:0] fold(input logic [31:0] acc, input logic [7:0] din,
                                         input logic sel16);
        return sel16 ? {acc[31:16], crc16_byte(acc[15:0], din)} : crc32_byte(acc, din);
    endfunction

    // Address phase is taken only while the bus is ready
    assign addr_take = hsel && htrans[1] && hready;

    // Data phase write strobes; hwdata is stable for the whole data phase
    assign dp_wr     = dp_valid_reg && dp_write_reg && dp_mapped_reg;
    assign wr_ctrl   = dp_wr && (dp_addr_reg == OFF_CTRL);
    assign wr_input  = dp_wr && (dp_addr_reg == OFF_INPUT);
    assign wr_window = dp_wr && (dp_addr_reg == OFF_WINDOW);
    assign wr_auto   = dp_wr && (dp_addr_reg == OFF_AUTO);
    assign wr_count  = dp_wr && (dp_addr_reg == OFF_COUNT);
    assign wr_bitrev = dp_wr && (dp_addr_reg == OFF_BITREV);
    assign rd_window = (state_reg == CKU_READ) && dp_mapped_reg
                       && (dp_addr_reg == OFF_WINDOW);

    // Enable as it will stand once an in-flight auto register write lands
    assign auto_en_eff = wr_auto ? hwdata[AUTO_EN_BIT] : auto_flash_enable_reg;

    // Control write seen in its address phase while auto is on; zero sectors do nothing
    assign auto_start = addr_take && hwrite && (haddr == {24'h000000, OFF_CTRL})
                        && auto_en_eff && (state_reg == CKU_IDLE)
                        && ((wr_count ? hwdata[COUNT_W-1:0] : sector_count_reg) != '0);

    assign auto_byte = (state_reg == CKU_AWAIT) && flash_rd_valid;

    // Pointer to result byte: 16-bit mode uses only the low pointer bit
    assign lane = poly_select_reg ? {1'b0, result_byte_pointer_reg[0]}
                                  : result_byte_pointer_reg;
    assign window_byte = result_reg[{lane, 3'b000} +: 8];

    // Mirror of the bit-reverse byte
    always_comb
    begin
        bitrev_view = BYTE_RST;
        for (int i = 0; i < 8; i++)
        begin
            bitrev_view[i] = bitrev_reg[7 - i];
        end
    end

    // Address phase capture
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp_valid_reg  <= 1'b0;
            dp_write_reg  <= 1'b0;
            dp_addr_reg   <= 8'h00;
            dp_mapped_reg <= 1'b0;
        end
        else if (addr_take)
        begin
            dp_valid_reg  <= 1'b1;
            dp_write_reg  <= hwrite;
            dp_addr_reg   <= haddr[7:0];
            dp_mapped_reg <= (haddr[31:8] == 24'h000000) && (haddr[7:0] <= OFF_BITREV)
                             && (haddr[1:0] == 2'b00);
        end
        // Writes land once; a stalled control write must not re-apply its init
        else if (hreadyout_reg || dp_write_reg)
        begin
            dp_valid_reg  <= 1'b0;
        end
    end

    // Sequencer: read wait state and the automatic flash sweep
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg      <= CKU_IDLE;
            hreadyout_reg  <= 1'b1;
            hresp_reg      <= 1'b0;
            remain_reg     <= '0;
            flash_rd_reg   <= 1'b0;
            flash_addr_reg <= '0;
        end
        else
        begin
            flash_rd_reg <= 1'b0;
            hresp_reg    <= 1'b0; // No error responses exist
            unique case (state_reg)
                CKU_IDLE:
                begin
                    if (auto_start)
                    begin
                        // Stall the control write until the sweep is done
                        hreadyout_reg  <= 1'b0;
                        state_reg      <= CKU_AREQ;
                        remain_reg     <= REMAIN_W'(wr_count ? hwdata[COUNT_W-1:0]
                                                             : sector_count_reg)
                                          << SECTOR_SHIFT;
                        flash_addr_reg <= FLASH_AW'(wr_auto
                                          ? hwdata[AUTO_PAGE_LSB +: PAGE_W]
                                          : start_page_reg) << SECTOR_SHIFT;
                    end
                    else if (addr_take && !hwrite)
                    begin
                        // One wait state lets any earlier write settle first
                        hreadyout_reg <= 1'b0;
                        state_reg     <= CKU_READ;
                    end
                end
                CKU_READ:
                begin
                    hreadyout_reg <= 1'b1;
                    state_reg     <= CKU_IDLE;
                end
                CKU_AREQ:
                begin
                    flash_rd_reg <= 1'b1;
                    state_reg    <= CKU_AWAIT;
                end
                CKU_AWAIT:
                begin
                    if (flash_rd_valid)
                    begin
                        remain_reg     <= remain_reg - 1'b1;
                        flash_addr_reg <= flash_addr_reg + 1'b1;
                        if (remain_reg == REMAIN_W'(1))
                        begin
                            hreadyout_reg <= 1'b1;
                            state_reg     <= CKU_IDLE;
                        end
                        else
                        begin
                            state_reg <= CKU_AREQ;
                        end
                    end
                end
            endcase
        end
    end

    // Read data, loaded in the wait state
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hrdata_reg <= 32'h0000_0000;
        end
        else if (state_reg == CKU_READ)
        begin
            hrdata_reg <= 32'h0000_0000;
            if (dp_mapped_reg)
            begin
                unique case (dp_addr_reg)
                    OFF_CTRL:   hrdata_reg[7:0] <= {3'b000, poly_select_reg, 1'b0,
                                                   preset_value_select_reg,
                                                   result_byte_pointer_reg};
                    OFF_INPUT:  hrdata_reg[7:0] <= byte_input_reg;
                    OFF_WINDOW: hrdata_reg[7:0] <= window_byte;
                    OFF_AUTO:   hrdata_reg[7:0] <= {auto_flash_enable_reg, 1'b0,
                                                   start_page_reg};
                    OFF_COUNT:  hrdata_reg[7:0] <= sector_count_reg;
                    OFF_BITREV: hrdata_reg[7:0] <= bitrev_view;
                    default:    hrdata_reg[7:0] <= 8'h00;
                endcase
            end
        end
    end

    // Control fields and the self-incrementing byte pointer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            poly_select_reg         <= 1'b0;
            preset_value_select_reg <= 1'b0;
            result_byte_pointer_reg <= PTR_RST;
        end
        else if (wr_ctrl)
        begin
            poly_select_reg         <= hwdata[CTL_SEL_BIT];
            preset_value_select_reg <= hwdata[CTL_VAL_BIT];
            result_byte_pointer_reg <= hwdata[CTL_PTR_LSB +: 2];
        end
        else if (wr_window || rd_window)
        begin
            result_byte_pointer_reg <= result_byte_pointer_reg + 2'd1;
        end
    end

    // Result register: sweep byte, input byte, window write or initialize
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_reg <= RESULT_RST;
        end
        else if (auto_byte)
        begin
            result_reg <= fold(result_reg, flash_rd_data, poly_select_reg);
        end
        else if (wr_input)
        begin
            result_reg <= fold(result_reg, hwdata[7:0], poly_select_reg);
        end
        else if (wr_window)
        begin
            result_reg[{lane, 3'b000} +: 8] <= hwdata[7:0];
        end
        else if (wr_ctrl && hwdata[CTL_INIT_BIT])
        begin
            // Preset uses the value select bit arriving in the same write
            result_reg <= hwdata[CTL_VAL_BIT] ? PRESET_ONES : PRESET_ZERO;
        end
    end

    // Plain storage registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            byte_input_reg        <= BYTE_RST;
            auto_flash_enable_reg <= 1'b0;
            start_page_reg        <= '0;
            sector_count_reg      <= '0;
            bitrev_reg            <= BYTE_RST;
        end
        else
        begin
            if (wr_input)
            begin
                byte_input_reg <= hwdata[7:0];
            end
            if (wr_auto)
            begin
                auto_flash_enable_reg <= hwdata[AUTO_EN_BIT];
                start_page_reg        <= hwdata[AUTO_PAGE_LSB +: PAGE_W];
            end
            if (wr_count)
            begin
                sector_count_reg <= hwdata[COUNT_W-1:0];
            end
            if (wr_bitrev)
            begin
                bitrev_reg <= hwdata[7:0];
            end
        end
    end

    // Outputs straight from flip-flops
    assign hrdata     = hrdata_reg;
    assign hreadyout  = hreadyout_reg;
    assign hresp      = hresp_reg;
    assign flash_rd   = flash_rd_reg;
    assign flash_addr = flash_addr_reg;

endmodule
`default_nettype wire

// ===== inc/cku_pkg.sv
// Constants, offsets and types shared by the checksum unit
`default_nettype none
package cku_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_INPUT  = 8'h04;
    localparam logic [7:0] OFF_WINDOW = 8'h08;
    localparam logic [7:0] OFF_AUTO   = 8'h0c;
    localparam logic [7:0] OFF_COUNT  = 8'h10;
    localparam logic [7:0] OFF_BITREV = 8'h14;
    // Control register fields
    localparam int CTL_SEL_BIT  = 4;
    localparam int CTL_INIT_BIT = 3;
    localparam int CTL_VAL_BIT  = 2;
    localparam int CTL_PTR_LSB  = 0;
    // Automatic control register fields
    localparam int AUTO_EN_BIT   = 7;
    localparam int AUTO_PAGE_LSB = 0;
    localparam int PAGE_W        = 6;
    // Widths
    localparam int FLASH_AW = 16;
    localparam int COUNT_W  = 8;
    localparam int REMAIN_W = 17;
    // Sector geometry: 512 bytes
    localparam int SECTOR_SHIFT = 9;
    // Generators and presets
    localparam logic [15:0] POLY16      = 16'h1021;
    localparam logic [31:0] POLY32_REFL = 32'hedb88320;
    localparam logic [31:0] PRESET_ONES = 32'hffff_ffff;
    localparam logic [31:0] PRESET_ZERO = 32'h0000_0000;
    // Reset values
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    localparam logic [7:0]  BYTE_RST   = 8'h00;
    localparam logic [1:0]  PTR_RST    = 2'h0;
    // Sequencer states, Gray on every step except AWAIT back to IDLE
    typedef enum logic [1:0] {
        CKU_IDLE  = 2'b00,
        CKU_AREQ  = 2'b01,
        CKU_AWAIT = 2'b11,
        CKU_READ  = 2'b10
    } cku_state_t;
endpackage
`default_nettype wire

// ===== bench/cku_checksum_unit_assertions.sv
// Concurrent checks on the bus and flash ports of the checksum unit
`timescale 1ns/100ps
`default_nettype none
module cku_checksum_unit_chk
    import cku_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                rst_n,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [2:0]          hsize,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic                flash_rd,
    input wire logic [FLASH_AW-1:0] flash_addr,
    input wire logic                flash_rd_valid,
    input wire logic [7:0]          flash_rd_data
);
    logic                dp_v;
    logic                dp_w;
    logic [7:0]          dp_a;
    logic [7:0]          last_rev;
    logic                seen;
    logic [FLASH_AW-1:0] last_fa;
    wire logic           take = hsel && htrans[1] && hready;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
    endfunction

    // Track the data phase; address only advances when the bus is ready
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n) begin dp_v <= 1'b0; dp_w <= 1'b0; dp_a <= 8'h00; end
        else if (hready) begin dp_v <= take; dp_w <= hwrite; dp_a <= haddr[7:0]; end
    end

    // Last byte written to the mirror register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n) last_rev <= 8'h00;
        else if (hready && dp_v && dp_w && dp_a == OFF_BITREV) last_rev <= hwdata[7:0];
    end

    // Sweep progress; a completed bus cycle ends any sweep
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n) begin seen <= 1'b0; last_fa <= '0; end
        else if (hreadyout) seen <= 1'b0;
        else if (flash_rd) begin seen <= 1'b1; last_fa <= flash_addr; end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence rd_take;
        take && !hwrite;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    AST_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_RD_WAIT: assert property (rd_take |=> rd_answer)
        else $error("read wait state wrong");
    AST_IN_NOWAIT: assert property (take && hwrite && haddr == {24'h0, OFF_INPUT} |=> hreadyout)
        else $error("input write stalled");
    AST_REV: assert property (rd_take ##0 haddr == {24'h0, OFF_BITREV} |=> ##1 hrdata[7:0] == rev8(last_rev))
        else $error("mirror byte wrong");
    AST_RD_HIGH: assert property (dp_v && !dp_w && hready |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_FL_STALL: assert property (flash_rd |-> !hreadyout)
        else $error("flash read without stall");
    AST_FL_PULSE: assert property (flash_rd |=> !flash_rd)
        else $error("flash request too long");
    AST_FL_START: assert property (flash_rd && !seen |-> flash_addr[SECTOR_SHIFT-1:0] == 9'h000)
        else $error("sweep not sector aligned");
    AST_FL_NEXT: assert property (flash_rd && seen |-> flash_addr == last_fa + 1'b1)
        else $error("flash address not consecutive");
    AST_FL_PACE: assert property (flash_rd_valid && !hreadyout |-> ##[1:4] (flash_rd || hreadyout))
        else $error("sweep stalled after byte");
endmodule

bind cku_checksum_unit cku_checksum_unit_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data));
`default_nettype wire

// ===== bench/cku_checksum_unit_bench.sv
// Self-checking bench for the checksum unit over its register bus
`timescale 1ns/100ps
`default_nettype none
module cku_checksum_unit_bench
    import cku_pkg::*;
;
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
    logic                ref_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                hsel = 1'b0;
    logic [31:0]         haddr = 32'h0;
    logic [1:0]          htrans = 2'h0;
    logic                hwrite = 1'b0;
    logic [31:0]         hwdata = 32'h0;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    logic                flash_rd;
    logic [FLASH_AW-1:0] flash_addr;
    logic                flash_rd_valid = 1'b0;
    logic [7:0]          flash_rd_data = 8'h00;
    logic [31:0]         res;
    logic [31:0]         rdv;
    logic [7:0]          rv;
    logic [7:0]          bytes [3] = '{8'haa, 8'hbb, 8'hcc};
    int                  err_total = 0;
    int                  n_tests = 0;
    int                  served = 0;
    logic [FLASH_AW-1:0] first_fa;

    cku_checksum_unit uut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rd_valid(flash_rd_valid),
        .flash_rd_data(flash_rd_data));

    initial forever #4 ref_clk = ~ref_clk;

    function automatic logic [7:0] fdat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic logic [31:0] c16(input logic [31:0] r, input logic [7:0] b);
        logic [15:0] c;
        c = r[15:0] ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ POLY16) : (c << 1);
        return {r[31:16], c};
    endfunction
    function automatic logic [31:0] c32(input logic [31:0] r, input logic [7:0] b);
        r = r ^ {24'h0, b};
        for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ POLY32_REFL) : (r >> 1);
        return r;
    endfunction

    // Flash answers one cycle after each request, so the wait is exercised
    always @(posedge ref_clk)
    begin
        flash_rd_valid <= flash_rd;
        flash_rd_data <= fdat(flash_addr);
        if (flash_rd === 1'b1) begin if (served == 0) first_fa = flash_addr; served++; end
    end

    // One single AHB transfer; waits on ready in both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        // No cycle limit here: a stall of any length is left to the watchdog
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    // Reads all four pointer slots twice; pointer wraps in 16-bit mode
    task automatic read_result(input logic sel);
        bus(1'b1, OFF_CTRL, {27'h0, sel, 4'h0});
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, OFF_WINDOW, 32'h0);
            `CHK(rdv[7:0], sel ? res[(i % 2)*8 +: 8] : res[(i % 4)*8 +: 8])
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watchdog sized well beyond the sweep and register traffic
    initial begin #400000; err_total++; complete_run(); end

    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Every polynomial and preset combination
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, OFF_CTRL, {27'h0, m[1], 1'b1, m[0], 2'h0});
            res = m[0] ? PRESET_ONES : PRESET_ZERO;
            read_result(m[1]);
            foreach (bytes[k]) begin
                bus(1'b1, OFF_INPUT, {24'h5a5a5a, bytes[k]});
                res = m[1] ? c16(res, bytes[k]) : c32(res, bytes[k]);
            end
            if (m == 3) `CHK(res[15:0], 16'h6cf6)
            if (m == 1) `CHK(res, 32'h41b207b3)
            read_result(m[1]);
            $display("test mode %0d done", m);
        end
        // Window write into byte two, then 32-bit view of whole result
        bus(1'b1, OFF_CTRL, 32'h02);
        bus(1'b1, OFF_WINDOW, 32'ha5);
        res[23:16] = 8'ha5;
        bus(1'b1, 8'h18, 32'hff);
        bus(1'b0, 8'h18, 32'h0);
        `CHK(rdv, 32'h0)
        read_result(1'b0);
        $display("test window done");
        // Mirror register
        for (int v = 1; v < 256; v = v * 3 + 2) begin
            bus(1'b1, OFF_BITREV, v);
            bus(1'b0, OFF_BITREV, 32'h0);
            rv = {<<{v[7:0]}};
            `CHK(rdv[7:0], rv)
        end
        $display("test mirror done");
        // Automatic sweep of one sector from page one
        bus(1'b1, OFF_CTRL, 32'h0c);
        bus(1'b1, OFF_AUTO, 32'h81);
        bus(1'b1, OFF_COUNT, 32'h01);
        served = 0;
        bus(1'b1, OFF_CTRL, 32'h00);
        `CHK(served, 512)
        `CHK(first_fa, 16'h0200)
        bus(1'b1, OFF_AUTO, 32'h00);
        res = PRESET_ONES;
        for (int a = 512; a < 1024; a++) res = c32(res, fdat(a[15:0]));
        read_result(1'b0);
        // Zero count starts nothing
        bus(1'b1, OFF_AUTO, 32'h81);
        bus(1'b1, OFF_COUNT, 32'h00);
        served = 0;
        bus(1'b1, OFF_CTRL, 32'h00);
        `CHK(served, 0)
        $display("test sweep done");
        complete_run();
    end
endmodule
`default_nettype wire
